// ===== include/spq_map.svh
// Purpose: constant map of the serial peripheral core
// Assumes: included by bare name, definitions only
// Notes: reset values, fill patterns, widths and receive buffer depth
`ifndef SPQ_MAP_SVH
`define SPQ_MAP_SVH
// ****************************************
// reset values, fill patterns, widths and buffer depth
// ****************************************
`define SPQ_WORD_BITS_DEF 8
`define SPQ_UNDERRUN_FILL 16'hffff
`define SPQ_FALSE_RX_WORD 16'h0000
`define SPQ_CS_IDLE 4'hf
`define SPQ_EDGE_CNT_W 6
`define SPQ_DIV_W 8
`define SPQ_RX_DEPTH 2'h2
`endif

// ===== include/spq_pkg.sv
// Purpose: shared types of the serial peripheral core
// Assumes: nothing imported, used as spq_pkg::name
// Notes: constants live in spq_map.svh
package spq_pkg;
   // transfer engine states
   typedef enum logic {SPQ_IDLE, SPQ_XFER} spq_state_e;
endpackage

// ===== logic/spq_spi_core.sv
// Purpose: master/slave serial peripheral core with revision quirks
// Assumes: all pins sampled synchronous to MCLK, one clock domain
// Notes: receive words pass a two-entry buffer; master stalls when full
`timescale 1ns/1ps
`include "spq_map.svh"

module spq_spi_core #(
   parameter int WORD_BITS = `SPQ_WORD_BITS_DEF
) (
   input wire logic MCLK,
   input wire logic RST,
   input wire logic SW_RESET,
   input wire logic ENABLE,
   input wire logic MASTER_MODE,
   input wire logic CPOL,
   input wire logic CPHA,
   input wire logic [1:0] CS_SEL,
   input wire logic [7:0] BAUD_DIV_CS0,
   input wire logic [7:0] BAUD_DIV_CS1,
   input wire logic [7:0] BAUD_DIV_CS2,
   input wire logic [7:0] BAUD_DIV_CS3,
   input wire logic TX_VALID,
   input wire logic [WORD_BITS-1:0] TX_DATA,
   output logic TX_READY,
   output logic RX_VALID,
   output logic [WORD_BITS-1:0] RX_DATA,
   input wire logic RX_READY,
   output logic ENABLED,
   input wire logic SCK_I,
   output logic SCK_O,
   output logic SCK_OE,
   input wire logic MOSI_I,
   output logic MOSI_O,
   output logic MOSI_OE,
   input wire logic MISO_I,
   output logic MISO_O,
   output logic MISO_OE,
   input wire logic SLAVE_SEL_N_I,
   output logic [3:0] CS_N
);
   // ****************************************
   // elaboration check
   // ****************************************
   if (WORD_BITS < 2 || WORD_BITS > 16) begin : g_chk
      $error("WORD_BITS must be 2..16");
   end

   localparam int EW = `SPQ_EDGE_CNT_W;
   localparam logic [EW-1:0] LAST_EDGE = EW'(2 * WORD_BITS - 1);

   // ****************************************
   // engine state
   // ****************************************
   spq_pkg::spq_state_e state_r, state_nxt; // transfer phase
   logic en_r, en_nxt; // interface enable
   logic en_prev_r, en_prev_nxt; // for enable edge
   logic [`SPQ_DIV_W-1:0] div_cnt_r, div_cnt_nxt; // half period count
   logic [EW-1:0] edge_cnt_r, edge_cnt_nxt; // clock edges in word
   logic extra_r, extra_nxt; // spurious pulse pending
   logic sck_r, sck_nxt; // driven serial clock
   logic sck_prev_r, sck_prev_nxt; // slave edge detect
   logic [WORD_BITS-1:0] tx_sr_r, tx_sr_nxt; // outgoing bits
   logic [WORD_BITS-1:0] rx_sr_r, rx_sr_nxt; // incoming bits
   logic [WORD_BITS-1:0] tx_hold_r, tx_hold_nxt; // transmit holding
   logic tx_full_r, tx_full_nxt; // holding occupied
   logic tx_ready_r, tx_ready_nxt; // registered ready
   logic out_bit_r, out_bit_nxt; // bit on mosi or miso
   logic [3:0] cs_n_r, cs_n_nxt; // chip selects
   logic last_div1_r, last_div1_nxt; // previous word had divider one
   logic used_r, used_nxt; // any master word sent yet
   logic sck_oe_r, sck_oe_nxt;
   logic mosi_oe_r, mosi_oe_nxt;
   logic miso_oe_r, miso_oe_nxt;
   logic push; // word into receive buffer
   logic [WORD_BITS-1:0] push_word;

   // ****************************************
   // receive buffer state
   // ****************************************
   logic [1:0] cnt_r, cnt_nxt; // words held
   logic [WORD_BITS-1:0] e0_r, e0_nxt; // head entry
   logic [WORD_BITS-1:0] e1_r, e1_nxt; // second entry
   logic valid_r, valid_nxt; // head valid

   // divider of the selected chip select
   logic [7:0] div_sel;
   always_comb begin
      unique case (CS_SEL)
         2'h0: div_sel = BAUD_DIV_CS0;
         2'h1: div_sel = BAUD_DIV_CS1;
         2'h2: div_sel = BAUD_DIV_CS2;
         default: div_sel = BAUD_DIV_CS3;
      endcase
   end

   // ****************************************
   // transfer engine, next values
   // ****************************************
   always_comb begin
      logic edge_ev; // one clock edge this cycle
      logic lead; // edge is the leading one
      logic [EW-1:0] d; // data edge index
      logic [7:0] reload; // half period minus one
      logic slave_sel;
      edge_ev = 1'b0;
      lead = 1'b0;
      d = '0;
      reload = (div_sel == 8'h00) ? 8'h00 : div_sel - 8'h01;
      slave_sel = en_r && !MASTER_MODE && !SLAVE_SEL_N_I;
      state_nxt = state_r;
      en_prev_nxt = en_r;
      div_cnt_nxt = div_cnt_r;
      edge_cnt_nxt = edge_cnt_r;
      extra_nxt = extra_r;
      sck_nxt = sck_r;
      sck_prev_nxt = SCK_I;
      tx_sr_nxt = tx_sr_r;
      rx_sr_nxt = rx_sr_r;
      tx_hold_nxt = tx_hold_r;
      tx_full_nxt = tx_full_r;
      out_bit_nxt = out_bit_r;
      cs_n_nxt = cs_n_r;
      last_div1_nxt = last_div1_r;
      used_nxt = used_r;
      push = 1'b0;
      push_word = rx_sr_r;
      // master clears enable; a slave ignores the clear
      if (ENABLE) begin
         en_nxt = 1'b1;
      end else if (MASTER_MODE) begin
         en_nxt = 1'b0;
      end else begin
         en_nxt = en_r;
      end
      // holding register takes a word when free
      if (TX_VALID && tx_ready_r) begin
         tx_hold_nxt = TX_DATA;
         tx_full_nxt = 1'b1;
      end
      unique case (state_r)
         spq_pkg::SPQ_IDLE: begin
            sck_nxt = CPOL;
            if (MASTER_MODE) begin
               cs_n_nxt = `SPQ_CS_IDLE;
            end
            // master waits for room so a finished word is never lost
            if (en_r && MASTER_MODE && tx_full_r && cnt_r != `SPQ_RX_DEPTH) begin
               state_nxt = spq_pkg::SPQ_XFER;
               tx_full_nxt = 1'b0;
               tx_sr_nxt = tx_hold_r;
               div_cnt_nxt = reload; // no prescale path exists
               edge_cnt_nxt = '0;
               cs_n_nxt = ~(4'h1 << CS_SEL); // no release option
               // with CPOL one and CPHA zero, divider one next to another divider glitches sck
               extra_nxt = CPOL && !CPHA && used_r &&
                  (last_div1_r != (div_sel == 8'h01));
               last_div1_nxt = (div_sel == 8'h01);
               used_nxt = 1'b1;
            end else if (slave_sel) begin
               state_nxt = spq_pkg::SPQ_XFER;
               edge_cnt_nxt = '0;
               extra_nxt = 1'b0;
               // empty holding: fill pattern goes out, nothing flags it
               if (tx_full_r) begin
                  tx_sr_nxt = tx_hold_r;
                  tx_full_nxt = 1'b0;
               end else begin
                  tx_sr_nxt = WORD_BITS'(`SPQ_UNDERRUN_FILL);
               end
            end
            // phase zero presents its first bit before any edge
            if (state_nxt == spq_pkg::SPQ_XFER && !CPHA) begin
               out_bit_nxt = tx_sr_nxt[WORD_BITS-1];
               tx_sr_nxt = tx_sr_nxt << 1;
            end
         end
         spq_pkg::SPQ_XFER: begin
            if (MASTER_MODE) begin
               if (div_cnt_r == 8'h00) begin
                  div_cnt_nxt = reload;
                  sck_nxt = ~sck_r;
                  edge_ev = 1'b1;
                  lead = (sck_r == CPOL);
               end else begin
                  div_cnt_nxt = div_cnt_r - 8'h01;
               end
            end else begin
               edge_ev = (SCK_I != sck_prev_r);
               lead = edge_ev && (SCK_I != CPOL);
            end
            if (edge_ev) begin
               edge_cnt_nxt = edge_cnt_r + EW'(1);
            end
            // dummy pulse uses two edges with no data action
            d = edge_cnt_r - (extra_r ? EW'(2) : EW'(0));
            if (edge_ev && !(extra_r && edge_cnt_r < EW'(2))) begin
               if (lead == !CPHA) begin
                  rx_sr_nxt = {rx_sr_r[WORD_BITS-2:0], MASTER_MODE ? MISO_I : MOSI_I};
               end else begin
                  out_bit_nxt = tx_sr_r[WORD_BITS-1];
                  tx_sr_nxt = tx_sr_r << 1;
               end
               if (d == LAST_EDGE) begin
                  state_nxt = spq_pkg::SPQ_IDLE;
                  push = 1'b1;
                  // select rises with the last edge, so back to back words
                  // still see one idle cycle with all selects high
                  cs_n_nxt = `SPQ_CS_IDLE;
                  push_word = (lead == !CPHA) ? rx_sr_nxt : rx_sr_r;
               end
            end
            // slave deselected mid word: abandon it
            if (!MASTER_MODE && !slave_sel) begin
               state_nxt = spq_pkg::SPQ_IDLE;
            end
         end
      endcase
      // slave enable edge leaks a false word into the buffer
      if (en_r && !en_prev_r && !MASTER_MODE) begin
         push = 1'b1;
         push_word = WORD_BITS'(`SPQ_FALSE_RX_WORD);
      end
      tx_ready_nxt = !tx_full_nxt;
      sck_oe_nxt = en_nxt && MASTER_MODE;
      mosi_oe_nxt = en_nxt && MASTER_MODE;
      miso_oe_nxt = slave_sel;
      // software reset drops the slave; the only way to stop one
      if (SW_RESET) begin
         state_nxt = spq_pkg::SPQ_IDLE;
         en_nxt = 1'b0;
         tx_full_nxt = 1'b0;
         tx_ready_nxt = 1'b1;
         cs_n_nxt = `SPQ_CS_IDLE;
         used_nxt = 1'b0;
         extra_nxt = 1'b0;
         sck_oe_nxt = 1'b0;
         mosi_oe_nxt = 1'b0;
         miso_oe_nxt = 1'b0;
      end
   end

   // ****************************************
   // transfer engine, registers
   // ****************************************
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         state_r <= spq_pkg::SPQ_IDLE;
         en_r <= 1'b0;
         en_prev_r <= 1'b0;
         div_cnt_r <= '0;
         edge_cnt_r <= '0;
         extra_r <= 1'b0;
         sck_r <= 1'b0;
         sck_prev_r <= 1'b0;
         tx_sr_r <= '0;
         rx_sr_r <= '0;
         tx_hold_r <= '0;
         tx_full_r <= 1'b0;
         tx_ready_r <= 1'b1;
         out_bit_r <= 1'b0;
         cs_n_r <= `SPQ_CS_IDLE;
         last_div1_r <= 1'b0;
         used_r <= 1'b0;
         sck_oe_r <= 1'b0;
         mosi_oe_r <= 1'b0;
         miso_oe_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         en_r <= en_nxt;
         en_prev_r <= en_prev_nxt;
         div_cnt_r <= div_cnt_nxt;
         edge_cnt_r <= edge_cnt_nxt;
         extra_r <= extra_nxt;
         sck_r <= sck_nxt;
         sck_prev_r <= sck_prev_nxt;
         tx_sr_r <= tx_sr_nxt;
         rx_sr_r <= rx_sr_nxt;
         tx_hold_r <= tx_hold_nxt;
         tx_full_r <= tx_full_nxt;
         tx_ready_r <= tx_ready_nxt;
         out_bit_r <= out_bit_nxt;
         cs_n_r <= cs_n_nxt;
         last_div1_r <= last_div1_nxt;
         used_r <= used_nxt;
         sck_oe_r <= sck_oe_nxt;
         mosi_oe_r <= mosi_oe_nxt;
         miso_oe_r <= miso_oe_nxt;
      end
   end

   // ****************************************
   // receive buffer, next values
   // ****************************************
   always_comb begin
      logic pop;
      pop = RX_READY && valid_r;
      cnt_nxt = cnt_r;
      e0_nxt = e0_r;
      e1_nxt = e1_r;
      // a full buffer drops a slave word; master never gets here full
      unique case ({push && (cnt_r != `SPQ_RX_DEPTH || pop), pop})
         2'b10: begin
            if (cnt_r == 2'h0) begin
               e0_nxt = push_word;
            end else begin
               e1_nxt = push_word;
            end
            cnt_nxt = cnt_r + 2'h1;
         end
         2'b01: begin
            e0_nxt = e1_r;
            cnt_nxt = cnt_r - 2'h1;
         end
         2'b11: begin
            e0_nxt = (cnt_r == 2'h1) ? push_word : e1_r;
            e1_nxt = push_word;
         end
         default: begin
            cnt_nxt = cnt_r;
         end
      endcase
      // software reset empties the buffer; a plain pop drops a false word
      if (SW_RESET) begin
         cnt_nxt = 2'h0;
      end
      valid_nxt = (cnt_nxt != 2'h0);
   end

   // ****************************************
   // receive buffer, registers
   // ****************************************
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         cnt_r <= 2'h0;
         e0_r <= '0;
         e1_r <= '0;
         valid_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         e0_r <= e0_nxt;
         e1_r <= e1_nxt;
         valid_r <= valid_nxt;
      end
   end

   // outputs straight from flip-flops
   assign TX_READY = tx_ready_r;
   assign RX_VALID = valid_r;
   assign RX_DATA = e0_r;
   assign ENABLED = en_r;
   assign SCK_O = sck_r;
   assign SCK_OE = sck_oe_r;
   assign MOSI_O = out_bit_r;
   assign MOSI_OE = mosi_oe_r;
   assign MISO_O = out_bit_r;
   assign MISO_OE = miso_oe_r;
   assign CS_N = cs_n_r;
endmodule

// ===== testbench/spq_core_checker.sv
// Purpose: port assertions of the serial core
// Assumes: bound to spq_spi_core, one clock domain
// Notes: sees top ports only, tags sit on label lines
`timescale 1ns/1ps
module spq_core_checker #(
   parameter int WORD_BITS = 8
) (
   input wire logic MCLK,
   input wire logic RST,
   input wire logic SW_RESET,
   input wire logic ENABLE,
   input wire logic MASTER_MODE,
   input wire logic TX_VALID,
   input wire logic TX_READY,
   input wire logic RX_VALID,
   input wire logic [WORD_BITS-1:0] RX_DATA,
   input wire logic RX_READY,
   input wire logic ENABLED,
   input wire logic SCK_O,
   input wire logic MOSI_OE,
   input wire logic MISO_OE,
   input wire logic [3:0] CS_N
);
   // ****************************************
   // serial clock edge counter per word
   // ****************************************
   localparam int TMIN = 2 * WORD_BITS - 1; // exact, the last edge always meets cs release and goes uncounted
   localparam int TMAX = 2 * WORD_BITS + 2; // one extra period allowed
   logic [7:0] tog_r, tog_nxt; // edges seen while a select is low
   logic sck_r; // previous clock level
   // next count, cleared whenever all selects idle
   always_comb begin
      tog_nxt = (&CS_N) ? 8'h00 : tog_r + 8'(SCK_O != sck_r);
   end
   // register only
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         tog_r <= 8'h00;
         sck_r <= 1'b0;
      end else begin
         tog_r <= tog_nxt;
         sck_r <= SCK_O;
      end
   end
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);
   // ****************************************
   // assertions
   // ****************************************
   chk_slave_stays_on: assert property (
      ENABLED && !MASTER_MODE && !SW_RESET |=> ENABLED)
      else $error("slave enable dropped without reset");
   chk_swreset_clears: assert property (
      SW_RESET |=> !ENABLED && !RX_VALID && TX_READY)
      else $error("software reset left state behind");
   chk_false_word: assert property (
      !ENABLED && ENABLE && !MASTER_MODE && !SW_RESET && !RX_VALID
      |=> ##[0:2] RX_VALID && RX_DATA == '0)
      else $error("no zero word after slave enable");
   chk_rx_stands: assert property (
      RX_VALID && !RX_READY && !SW_RESET |=> RX_VALID && $stable(RX_DATA))
      else $error("received word lost before read");
   chk_tx_taken: assert property (
      TX_VALID && TX_READY && !SW_RESET |=> !TX_READY)
      else $error("holding word not taken");
   chk_drive_apart: assert property (
      !(MOSI_OE && MISO_OE))
      else $error("both data lines driven");
   chk_extra_pulse: assert property (
      $rose(&CS_N) |-> tog_r inside {[TMIN:TMAX]})
      else $error("clock edge count per word off");
   chk_master_start: assert property (
      ENABLED && MASTER_MODE && TX_VALID && TX_READY && (&CS_N) && !RX_VALID && !SW_RESET
      |=> ##[0:8] !(&CS_N))
      else $error("master word did not start");
endmodule

bind spq_spi_core spq_core_checker #(.WORD_BITS(WORD_BITS)) chk_u (
   .MCLK(MCLK), .RST(RST), .SW_RESET(SW_RESET), .ENABLE(ENABLE), .MASTER_MODE(MASTER_MODE),
   .TX_VALID(TX_VALID), .TX_READY(TX_READY), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA),
   .RX_READY(RX_READY), .ENABLED(ENABLED), .SCK_O(SCK_O), .MOSI_OE(MOSI_OE),
   .MISO_OE(MISO_OE), .CS_N(CS_N));

// ===== testbench/spq_peer_model.sv
// Purpose: far-side serial device, echo slave and word master
// Assumes: half period of four clocks when acting as master
// Notes: lines not driven carry changing or inverted levels
`timescale 1ns/1ps
module spq_peer_model (
   input wire logic mclk,
   input wire logic [3:0] cs_n,
   input wire logic mosi,
   input wire logic miso,
   output logic sck_p,
   output logic mosi_p,
   output logic miso_p,
   output logic sel_n_p
);
   logic last_r; // last echoed bit
   logic busy; // frame in progress
   initial begin
      sck_p = 1'b0;
      mosi_p = 1'b0;
      sel_n_p = 1'b1;
      busy = 1'b0;
      last_r = 1'b0;
   end
   // echo while selected, inverse of last bit once released
   always @(posedge mclk) if (!(&cs_n)) last_r <= mosi;
   assign miso_p = (&cs_n) ? ~last_r : mosi;
   // idle data line keeps moving so no stale value reads as good
   always @(negedge mclk) if (!busy) mosi_p <= ~mosi_p;
   // one word as master, mode 0, msb first, clock still outside
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      busy = 1'b1;
      @(negedge mclk);
      sel_n_p = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         mosi_p = tx[i];
         repeat (4) @(negedge mclk);
         rx = {rx[6:0], miso};
         sck_p = 1'b1;
         repeat (4) @(negedge mclk);
         sck_p = 1'b0;
      end
      repeat (4) @(negedge mclk);
      sel_n_p = 1'b1;
      busy = 1'b0;
   endtask
endmodule

// ===== testbench/tb_top.sv
// Purpose: self-checking bench of the serial core
// Assumes: inputs change at the falling edge
// Notes: peer echoes data back in master mode
`timescale 1ns/1ps
module tb_top;
   logic mclk, rst, sw_rst, en, mst, cpol, cpha, tx_v, tx_rdy, rx_v, rx_rdy, ena;
   logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, p_sck, p_mosi, p_miso, p_sel_n;
   logic [1:0] cs_sel;
   logic [3:0] cs_n;
   logic [7:0] d0, d1, tx_d, rx_d, got;
   logic sck_d;
   int fail_count, compares, tog;
   // wire levels from all drivers
   wire sck_w = sck_oe ? sck_o : p_sck;
   wire mosi_w = mosi_oe ? mosi_o : p_mosi;
   wire miso_w = miso_oe ? miso_o : p_miso;
   spq_spi_core #(.WORD_BITS(8)) dut_u (
      .MCLK(mclk), .RST(rst), .SW_RESET(sw_rst), .ENABLE(en), .MASTER_MODE(mst),
      .CPOL(cpol), .CPHA(cpha), .CS_SEL(cs_sel), .BAUD_DIV_CS0(d0), .BAUD_DIV_CS1(d1),
      .BAUD_DIV_CS2(d0), .BAUD_DIV_CS3(d0), .TX_VALID(tx_v), .TX_DATA(tx_d),
      .TX_READY(tx_rdy), .RX_VALID(rx_v), .RX_DATA(rx_d), .RX_READY(rx_rdy), .ENABLED(ena),
      .SCK_I(sck_w), .SCK_O(sck_o), .SCK_OE(sck_oe), .MOSI_I(mosi_w), .MOSI_O(mosi_o),
      .MOSI_OE(mosi_oe), .MISO_I(miso_w), .MISO_O(miso_o), .MISO_OE(miso_oe),
      .SLAVE_SEL_N_I(p_sel_n), .CS_N(cs_n));
   spq_peer_model pm_u (.mclk(mclk), .cs_n(cs_n), .mosi(mosi_w), .miso(miso_w),
      .sck_p(p_sck), .mosi_p(p_mosi), .miso_p(p_miso), .sel_n_p(p_sel_n));
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // serial clock edges, sampled where settled
   always @(negedge mclk) begin
      if (sck_o !== sck_d) tog++;
      sck_d <= sck_o;
   end
   // whole run is well under a thousand cycles, far below the 20000 cycle limit
   initial begin
      repeat (20000) @(posedge mclk);
      fail_count++;
      tally_and_finish();
   end
   task automatic cmp(input logic [15:0] g, input logic [15:0] e);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic tally_and_finish;
      if (fail_count == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // hold word until a settled ready lets the next edge take it
   task automatic send(input logic [7:0] d);
      @(negedge mclk);
      tx_v = 1'b1;
      tx_d = d;
      while (tx_rdy !== 1'b1) @(negedge mclk);
      @(negedge mclk);
      tx_v = 1'b0;
   endtask
   task automatic pop(input logic [7:0] e);
      // one edge apart from a previous pop, so rx_rdy never moves twice at once
      @(negedge mclk);
      while (rx_v !== 1'b1) @(negedge mclk);
      cmp(rx_d, e);
      rx_rdy = 1'b1;
      @(negedge mclk);
      rx_rdy = 1'b0;
   endtask
   initial begin
      rst = 1'b1;
      sw_rst = 1'b0;
      en = 1'b0;
      mst = 1'b1;
      cpol = 1'b0;
      cpha = 1'b0;
      cs_sel = 2'h0;
      d0 = 8'h01;
      d1 = 8'h01;
      tx_v = 1'b0;
      tx_d = 8'h00;
      rx_rdy = 1'b0;
      fail_count = 0;
      compares = 0;
      tog = 0;
      sck_d = 1'b0;
      repeat (12) @(negedge mclk);
      cmp(cs_n, 4'hf);
      cmp({tx_rdy, rx_v, ena, sck_oe}, 4'h8);
      rst = 1'b0;
      en = 1'b1;
      // every clock mode through the echo
      for (int m = 0; m < 4; m++) begin
         {cpol, cpha} = 2'(m);
         send(8'h5a ^ 8'(m));
         pop(8'h5a ^ 8'(m));
      end
      // two words buffered, third held back
      send(8'ha1);
      send(8'ha2);
      send(8'ha3);
      repeat (80) @(negedge mclk);
      cmp(tx_rdy, 1'b0);
      pop(8'ha1);
      pop(8'ha2);
      pop(8'ha3);
      // mixed dividers on purpose to provoke the extra period
      cpol = 1'b1;
      cpha = 1'b0;
      d1 = 8'h02;
      repeat (3) @(negedge mclk);
      for (int k = 0; k < 3; k++) begin
         cs_sel = 2'(k & 1);
         tog = 0;
         send(8'hc0 + 8'(k));
         pop(8'hc0 + 8'(k));
         cmp(tog[15:0], (k == 0) ? 16'h10 : 16'h12);
      end
      // slave: enable, flip polarity, drain the false word
      en = 1'b0;
      sw_rst = 1'b1;
      @(negedge mclk);
      sw_rst = 1'b0;
      mst = 1'b0;
      cpol = 1'b0;
      @(negedge mclk);
      en = 1'b1;
      repeat (3) @(negedge mclk);
      cmp(rx_v, 1'b1);
      cpol = 1'b1;
      @(negedge mclk);
      cpol = 1'b0;
      @(negedge mclk);
      pop(8'h00);
      en = 1'b0;
      repeat (4) @(negedge mclk);
      cmp(ena, 1'b1);
      pm_u.xfer(8'h3c, got);
      cmp(got, 8'hff);
      pop(8'h3c);
      send(8'h96);
      pm_u.xfer(8'h69, got);
      cmp(got, 8'h96);
      pop(8'h69);
      sw_rst = 1'b1;
      @(negedge mclk);
      sw_rst = 1'b0;
      cmp({ena, rx_v}, 2'h0);
      tally_and_finish();
   end
endmodule
